// ### common/bdc_map.svh
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH

// Register indices; byte address is four times the index
`define BDC_IDX_DEV_CFG2     8'h1B
`define BDC_IDX_BAL_DIAG     8'h1C
`define BDC_IDX_DCHG_CFG     8'h1D
`define BDC_IDX_TOP_CELL     8'h1E
`define BDC_IDX_MEAS_EN      8'h40
`define BDC_IDX_MUX_POL      8'h41
`define BDC_IDX_INT_STATUS   8'h42
`define BDC_IDX_INT_MASK     8'h43

// Field positions
`define BDC_DIAG_ALT_BIT     13
`define BDC_DIAG_POL_BIT     12
`define BDC_DCHG_WIN_LSB     13
`define BDC_DCHG_CNT_LSB     8
`define BDC_CFG2_EMG_BIT     8
`define BDC_MUX_ALT_BIT      1
`define BDC_MUX_POL_BIT      0
`define BDC_INT_TIMEOUT      0
`define BDC_INT_PERIOD       1
`define BDC_INT_ALERT        2

// Reset values
`define BDC_TOP_CELL_RST     4'hC
`define BDC_VERIFY_RST       4'hF

// Timing: clock rate, tick and step lengths
`define BDC_CLK_MHZ          200
`define BDC_TICK_US          62500
`define BDC_STEP_US          7500000
`define BDC_PERIOD_S         60
`define BDC_TMO_STEP_S       7200
`define BDC_STEP_TICKS       (`BDC_STEP_US / `BDC_TICK_US)
`define BDC_PERIOD_TICKS     (`BDC_PERIOD_S * 1000000 / `BDC_TICK_US)
`define BDC_TMO_PERIODS      (`BDC_TMO_STEP_S / `BDC_PERIOD_S)

`endif

// ### common/bdc_pkg.sv
package bdc_pkg;

  // One bit per cell channel
  typedef logic [11:0] bdc_cells_t;
  // Discharge window code
  typedef logic [2:0]  bdc_win_t;
  // Interrupt event vector
  typedef logic [2:0]  bdc_events_t;

endpackage

// ### design/bdc_discharge_timer.sv
`timescale 1ns/100ps
`include "bdc_map.svh"

module bdc_discharge_timer
  import bdc_pkg::*;
#(
  parameter int TICK_CYCLES  = `BDC_TICK_US * `BDC_CLK_MHZ,
  parameter int PERIOD_TICKS = `BDC_PERIOD_TICKS,
  parameter int STEP_TICKS   = `BDC_STEP_TICKS,
  parameter int TMO_PERIODS  = `BDC_TMO_PERIODS
)
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  // Configuration
  input  wire logic       i_active,
  input  wire bdc_win_t   i_window,
  input  wire logic [7:0] i_timeout,
  // Results
  output logic            o_switch_on,
  output logic [3:0]      o_verify_count,
  output logic            o_period_pulse,
  output logic            o_expired
);

  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);
  localparam logic [9:0]    PHASE_LAST = 10'(PERIOD_TICKS - 1);

  logic [PW-1:0] pre;
  logic [9:0]    phase;
  logic [15:0]   pcnt;

  // Tick, period wrap and limits
  wire        tick = i_active & (pre == TICK_LAST);
  wire        wrap = tick & (phase == PHASE_LAST);
  wire [9:0]  on_ticks = (i_window == 3'h7) ? PHASE_LAST
                       : 10'((int'(i_window) + 1) * STEP_TICKS);
  wire [15:0] limit = 16'((int'(i_timeout) + 1) * TMO_PERIODS);
  wire [15:0] next_pcnt = pcnt + 16'h0001;
  wire [9:0]  next_phase = (!i_active || wrap) ? 10'h000
                         : tick ? phase + 10'h001 : phase;
  wire        expire = wrap & (next_pcnt >= limit);

  // Prescaler down to one tick every 62.5 ms
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      pre <= '0;
    else
      pre <= (!i_active || tick) ? '0 : pre + 1'b1;
  end

  // Phase within the 60 s cycle and elapsed cycles
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      phase <= 10'h000;
      pcnt  <= 16'h0000;
    end
    else
    begin
      phase <= next_phase;                              // [RULE_15]
      pcnt  <= !i_active ? 16'h0000 : wrap ? next_pcnt : pcnt;
    end
  end

  // Switch window, verify counter and events
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_switch_on    <= 1'b0;
      o_verify_count <= `BDC_VERIFY_RST;
      o_period_pulse <= 1'b0;
      o_expired      <= 1'b0;
    end
    else
    begin
      // Current phase keeps the first on stretch a full tick long
      o_switch_on    <= i_active & (phase < on_ticks); // [RULE_05] [RULE_06] [RULE_07] [RULE_08]
      o_verify_count <= !i_active ? `BDC_VERIFY_RST
                      : wrap ? o_verify_count - 4'h1 : o_verify_count; // [RULE_09]
      o_period_pulse <= wrap;
      o_expired      <= expire;                         // [RULE_11]
    end
  end

endmodule // bdc_discharge_timer

// ### design/bdc_balance_discharge.sv
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "bdc_map.svh"

// Functional notes
// RULE_01 - Reserved register bits always read zero
// RULE_02 - Diag bit 13 mirrors alternate mux select
// RULE_03 - Diag bit 12 mirrors polarity setting
// RULE_04 - Cell enable mirror reads/writes measure enables
// RULE_05 - Window code sets duty, 7.5 s steps
// RULE_06 - Code 0: on 7.5 s, off 52.5 s
// RULE_07 - Code 1: on 15 s, off 45 s
// RULE_08 - Code 7: on 59.94 s, off 62.5 ms
// RULE_09 - Verify counter counts F down to 0, repeating
// RULE_10 - Timeout code zero disables discharge immediately
// RULE_11 - Code n ends discharge after (n+1)*2 hours
// RULE_12 - Top cell masks alerts above it
// RULE_13 - Top cell resets to 12; zero means 12
// RULE_14 - Discharge runs only while enable bit set
// RULE_15 - Fixed 60 s cycle split on/off
module bdc_balance_discharge
  import bdc_pkg::*;
#(
  parameter int TICK_CYCLES = `BDC_TICK_US * `BDC_CLK_MHZ
)
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Balancing switch diagnostics
  input  wire bdc_cells_t  i_balance_switch_alert,
  output bdc_cells_t       o_balance_switch_alert,
  // Measurement controls
  output bdc_cells_t       o_cell_measure_enables,
  output logic             o_alt_mux_select,
  output logic             o_polarity,
  // Emergency discharge
  output logic             o_emergency_discharge_enable,
  output logic             o_discharge_switch_on,
  // Interrupt
  output logic             o_irq
);

  // Register state
  bdc_cells_t  cell_measure_enables;
  logic        alt_mux_select;
  logic        polarity;
  logic        emergency_discharge_enable;
  bdc_win_t    discharge_window;
  logic [7:0]  discharge_timeout;
  logic [3:0]  top_cell_position;
  bdc_events_t int_status;
  bdc_events_t int_mask;
  bdc_cells_t  alert_q;
  logic        irq_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // Discharge timer results
  logic        switch_on;
  logic [3:0]  discharge_verify_counter;
  logic        period_pulse;
  logic        expired;

  // Bus phases: read data is built in the first access cycle
  wire         acc_first = i_psel & i_penable & ~pready_q;
  wire         acc_done  = i_psel & i_penable & pready_q;
  wire         wr        = acc_done & i_pwrite;
  wire [7:0]   word      = i_paddr[9:2];
  wire         hi_ok     = (i_paddr[11:10] == 2'b00);

  // Address decode
  wire sel_cfg2 = hi_ok & (word == `BDC_IDX_DEV_CFG2);
  wire sel_diag = hi_ok & (word == `BDC_IDX_BAL_DIAG);
  wire sel_dchg = hi_ok & (word == `BDC_IDX_DCHG_CFG);
  wire sel_top  = hi_ok & (word == `BDC_IDX_TOP_CELL);
  wire sel_meas = hi_ok & (word == `BDC_IDX_MEAS_EN);
  wire sel_mux  = hi_ok & (word == `BDC_IDX_MUX_POL);
  wire sel_stat = hi_ok & (word == `BDC_IDX_INT_STATUS);
  wire sel_mask = hi_ok & (word == `BDC_IDX_INT_MASK);
  wire mapped   = sel_cfg2 | sel_diag | sel_dchg | sel_top
                | sel_meas | sel_mux | sel_stat | sel_mask;

  // Write strobes, taken on the completing access edge
  wire wr_cfg2 = wr & sel_cfg2;
  wire wr_diag = wr & sel_diag;
  wire wr_dchg = wr & sel_dchg;
  wire wr_top  = wr & sel_top;
  wire wr_meas = wr & sel_meas;
  wire wr_mux  = wr & sel_mux;
  wire wr_stat = wr & sel_stat;
  wire wr_mask = wr & sel_mask;

  // Read values with reserved bits forced to zero
  wire [31:0] diag_rd = {16'h0000, 2'b00, alt_mux_select, polarity,
                         cell_measure_enables};           // [RULE_01]
  wire [31:0] dchg_rd = {16'h0000, discharge_window, 1'b0,
                         discharge_verify_counter,
                         discharge_timeout};              // [RULE_01]
  wire [31:0] cfg2_rd = {16'h0000, 7'h00,
                         emergency_discharge_enable, 8'h00};
  wire [31:0] top_rd  = {28'h0000000, top_cell_position}; // [RULE_01]
  wire [31:0] meas_rd = {16'h0000, 3'h0, cell_measure_enables, 1'b0};
  wire [31:0] mux_rd  = {30'h00000000, alt_mux_select, polarity};
  wire [31:0] stat_rd = {29'h00000000, int_status};
  wire [31:0] mask_rd = {29'h00000000, int_mask};

  // Read data selection
  wire [31:0] rd_value = ({32{sel_cfg2}} & cfg2_rd)
                       | ({32{sel_diag}} & diag_rd)
                       | ({32{sel_dchg}} & dchg_rd)
                       | ({32{sel_top}}  & top_rd)
                       | ({32{sel_meas}} & meas_rd)
                       | ({32{sel_mux}}  & mux_rd)
                       | ({32{sel_stat}} & stat_rd)
                       | ({32{sel_mask}} & mask_rd);

  // Discharge runs only while enabled with a nonzero timeout
  wire active = emergency_discharge_enable
              & (discharge_timeout != 8'h00);      // [RULE_10] [RULE_14]

  // Effective top cell: zero and out-of-range codes count as 12
  wire [3:0] top_eff = ((top_cell_position == 4'h0) ||
                        (top_cell_position > `BDC_TOP_CELL_RST))
                     ? `BDC_TOP_CELL_RST : top_cell_position; // [RULE_13]

  // Channels at or below the top cell stay live
  bdc_cells_t chan_live;
  genvar gi;
  generate
    for (gi = 0; gi < 12; gi = gi + 1)
    begin : g_live
      assign chan_live[gi] = (4'(gi) < top_eff);   // [RULE_12]
    end
  endgenerate

  // Masked alerts and interrupt events
  wire bdc_cells_t masked_alert = i_balance_switch_alert & chan_live;
  bdc_events_t events;
  assign events[`BDC_INT_TIMEOUT] = expired;
  assign events[`BDC_INT_PERIOD]  = period_pulse;
  assign events[`BDC_INT_ALERT]   = |masked_alert;

  // Sticky status: a new event wins over a write-one clear
  wire bdc_events_t clr_bits = wr_stat ? i_pwdata[2:0] : 3'b000;
  wire bdc_events_t next_int_status = (int_status & ~clr_bits) | events;
  wire next_irq = |(next_int_status & int_mask);

  // Cell enables, shared by the mirror and the measure register
  wire bdc_cells_t next_cell_measure_enables =
      wr_diag ? i_pwdata[11:0]                      // [RULE_04]
    : wr_meas ? i_pwdata[12:1]
    : cell_measure_enables;

  // Mux select and polarity, shared by mirror and own register
  wire next_alt_mux_select =
      wr_diag ? i_pwdata[`BDC_DIAG_ALT_BIT]         // [RULE_02]
    : wr_mux  ? i_pwdata[`BDC_MUX_ALT_BIT]
    : alt_mux_select;
  wire next_polarity =
      wr_diag ? i_pwdata[`BDC_DIAG_POL_BIT]         // [RULE_03]
    : wr_mux  ? i_pwdata[`BDC_MUX_POL_BIT]
    : polarity;

  // Enable: software write wins, timeout expiry clears it
  wire next_emergency_discharge_enable =
      wr_cfg2 ? i_pwdata[`BDC_CFG2_EMG_BIT]
    : expired ? 1'b0                                // [RULE_11]
    : emergency_discharge_enable;

  // Measurement control registers
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cell_measure_enables <= 12'h000;
      alt_mux_select       <= 1'b0;
      polarity             <= 1'b0;
    end
    else
    begin
      cell_measure_enables <= next_cell_measure_enables;
      alt_mux_select       <= next_alt_mux_select;
      polarity             <= next_polarity;
    end
  end

  // Emergency discharge configuration
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      emergency_discharge_enable <= 1'b0;
      discharge_window           <= 3'h0;
      discharge_timeout          <= 8'h00;
    end
    else
    begin
      emergency_discharge_enable <= next_emergency_discharge_enable;
      if (wr_dchg)
      begin
        discharge_window  <= i_pwdata[`BDC_DCHG_WIN_LSB +: 3]; // [RULE_05]
        discharge_timeout <= i_pwdata[7:0];          // [RULE_10]
      end
    end
  end

  // Top cell position
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      top_cell_position <= `BDC_TOP_CELL_RST;       // [RULE_13]
    else if (wr_top)
      top_cell_position <= i_pwdata[3:0];
  end

  // Interrupt status, mask and output
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      int_status <= 3'b000;
      int_mask   <= 3'b000;
      irq_q      <= 1'b0;
    end
    else
    begin
      int_status <= next_int_status;
      int_mask   <= wr_mask ? i_pwdata[2:0] : int_mask;
      irq_q      <= next_irq;
    end
  end

  // Registered alert outputs for live channels only
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
      alert_q <= 12'h000;
    else
      alert_q <= masked_alert;                      // [RULE_12]
  end

  // APB answer: one wait state, read data and error registered
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc_first;
      if (acc_first)
      begin
        prdata_q  <= i_pwrite ? 32'h00000000 : rd_value;
        pslverr_q <= ~mapped;
      end
      else
        pslverr_q <= 1'b0;
    end
  end

  // Duty-cycle window, verify counter and timeout
  bdc_discharge_timer #(
    .TICK_CYCLES  (TICK_CYCLES)
  ) u_timer (
    .i_mclk         (i_mclk),
    .i_resetn       (i_resetn),
    .i_active       (active),                       // [RULE_14]
    .i_window       (discharge_window),
    .i_timeout      (discharge_timeout),
    .o_switch_on    (switch_on),
    .o_verify_count (discharge_verify_counter),
    .o_period_pulse (period_pulse),
    .o_expired      (expired)
  );

  // Outputs straight from flip-flops
  assign o_prdata                     = prdata_q;
  assign o_pready                     = pready_q;
  assign o_pslverr                    = pslverr_q;
  assign o_balance_switch_alert       = alert_q;
  assign o_cell_measure_enables       = cell_measure_enables;
  assign o_alt_mux_select             = alt_mux_select;
  assign o_polarity                   = polarity;
  assign o_emergency_discharge_enable = emergency_discharge_enable;
  assign o_discharge_switch_on        = switch_on;
  assign o_irq                        = irq_q;

endmodule // bdc_balance_discharge

// ### tb/bdc_checker_asserts.sv
`timescale 1ns/100ps
`include "bdc_map.svh"

module bdc_checker_asserts
  import bdc_pkg::*;
#(
  parameter int TICK_CYCLES = 4
)
(
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  // APB slave
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // Cells, controls and discharge
  input wire bdc_cells_t  i_balance_switch_alert,
  input wire bdc_cells_t  o_balance_switch_alert,
  input wire bdc_cells_t  o_cell_measure_enables,
  input wire logic        o_alt_mux_select,
  input wire logic        o_polarity,
  input wire logic        o_emergency_discharge_enable,
  input wire logic        o_discharge_switch_on,
  input wire logic        o_irq
);
  localparam int PERIOD = 960 * TICK_CYCLES;
  // Completed write and its word index
  wire logic       wr_done;
  wire logic [7:0] idx;
  assign wr_done = i_psel && i_penable && i_pwrite && o_pready
                   && (i_paddr[11:10] == 2'b00);
  assign idx = i_paddr[9:2];
  // Access outside the register map
  wire logic       unmapped;
  assign unmapped = (i_paddr[11:10] != 2'b00)
                    || !(idx inside {`BDC_IDX_DEV_CFG2, `BDC_IDX_BAL_DIAG,
                         `BDC_IDX_DCHG_CFG, `BDC_IDX_TOP_CELL,
                         `BDC_IDX_MEAS_EN, `BDC_IDX_MUX_POL,
                         `BDC_IDX_INT_STATUS, `BDC_IDX_INT_MASK});
  logic [31:0] on_run;

  // Length of the current switch-on stretch
  always_ff @(posedge i_mclk or negedge i_resetn)
    if (!i_resetn)
      on_run <= '0;
    else
      on_run <= o_discharge_switch_on ? on_run + 32'h1 : '0;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable;
  endsequence

  a_ready_one_wait: assert property (s_setup ##1 s_access |=> o_pready)
    else $error("pready not after one wait state");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (s_setup ##1
    (s_access and unmapped) |=> o_pslverr)
    else $error("unmapped access not refused");
  a_diag_mirror: assert property (wr_done && idx == `BDC_IDX_BAL_DIAG
    |=> o_cell_measure_enables == $past(i_pwdata[11:0])
    && o_alt_mux_select == $past(i_pwdata[13])
    && o_polarity == $past(i_pwdata[12]))
    else $error("diag mirror write lost");
  a_meas_en_write: assert property (wr_done && idx == `BDC_IDX_MEAS_EN
    |=> o_cell_measure_enables == $past(i_pwdata[12:1]))
    else $error("cell enable write lost");
  a_alert_subset: assert property ((o_balance_switch_alert
    & ~$past(i_balance_switch_alert)) == 12'h000)
    else $error("alert out without alert in");
  a_tmo_zero_stop: assert property (wr_done && idx == `BDC_IDX_DCHG_CFG
    && i_pwdata[7:0] == 8'h00 |=> ##[0:1] !o_discharge_switch_on)
    else $error("zero timeout did not stop discharge");
  a_enable_gate: assert property (!o_emergency_discharge_enable[*3]
    |-> !o_discharge_switch_on)
    else $error("switch on while disabled");
  a_on_bounded: assert property (on_run < PERIOD)
    else $error("switch on for a whole cycle");
endmodule // bdc_checker_asserts

bind bdc_balance_discharge bdc_checker_asserts
  #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
  .i_balance_switch_alert(i_balance_switch_alert),
  .o_balance_switch_alert(o_balance_switch_alert),
  .o_cell_measure_enables(o_cell_measure_enables),
  .o_alt_mux_select(o_alt_mux_select), .o_polarity(o_polarity),
  .o_emergency_discharge_enable(o_emergency_discharge_enable),
  .o_discharge_switch_on(o_discharge_switch_on));

// ### tb/balance_discharge_config_test.sv
`timescale 1ns/100ps
`include "bdc_map.svh"

module balance_discharge_config_test;
  import bdc_pkg::*;
  localparam int TC = 4;
  localparam int PER = 960 * TC;
  // Bench signals
  logic        i_mclk = 0, i_resetn = 0, i_psel = 0, i_penable = 0;
  logic        i_pwrite = 0, o_pready, o_pslverr, o_irq, err;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata, rd;
  logic        o_alt_mux_select, o_polarity, o_discharge_switch_on;
  logic        o_emergency_discharge_enable, m_alt = 0, m_pol = 0, m_en = 0;
  bdc_cells_t  i_balance_switch_alert = '0, o_balance_switch_alert;
  bdc_cells_t  o_cell_measure_enables, m_cells = '0;
  logic [2:0]  m_win = '0, m_mask = '0;
  logic [7:0]  m_tmo = '0;
  logic [3:0]  m_top = 4'hC, m_cnt = 4'hF;
  logic [15:0] rnd = 16'hEA2C;
  logic [7:0]  regs [7] = '{`BDC_IDX_DEV_CFG2, `BDC_IDX_BAL_DIAG,
    `BDC_IDX_DCHG_CFG, `BDC_IDX_TOP_CELL, `BDC_IDX_MEAS_EN,
    `BDC_IDX_MUX_POL, `BDC_IDX_INT_MASK};
  int num_errors = 0, tests_run = 0, n, on, off, wv, eff;

  bdc_balance_discharge #(.TICK_CYCLES(TC)) dut (.i_mclk(i_mclk),
    .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_balance_switch_alert(i_balance_switch_alert),
    .o_balance_switch_alert(o_balance_switch_alert),
    .o_cell_measure_enables(o_cell_measure_enables),
    .o_alt_mux_select(o_alt_mux_select), .o_polarity(o_polarity),
    .o_emergency_discharge_enable(o_emergency_discharge_enable),
    .o_discharge_switch_on(o_discharge_switch_on), .o_irq(o_irq));

  // Clock
  initial forever #2.5 i_mclk = ~i_mclk;

  // Pseudo-random source
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {2'b00, i, 2'b00};
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    do @(posedge i_mclk); while (o_pready !== 1'b1 && ++k < 20);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (k >= 20)
      num_errors++;
  endtask

  // Model: expected read value of a register
  function automatic logic [31:0] exp_rd(input logic [7:0] i);
    case (i)
      `BDC_IDX_DEV_CFG2: return {23'h0, m_en, 8'h00};
      `BDC_IDX_BAL_DIAG: return {18'h0, m_alt, m_pol, m_cells};
      `BDC_IDX_DCHG_CFG: return {16'h0, m_win, 1'b0, m_cnt, m_tmo};
      `BDC_IDX_TOP_CELL: return {28'h0, m_top};
      `BDC_IDX_MEAS_EN:  return {19'h0, m_cells, 1'b0};
      `BDC_IDX_MUX_POL:  return {30'h0, m_alt, m_pol};
      `BDC_IDX_INT_MASK: return {29'h0, m_mask};
      default:           return 32'h0;
    endcase
  endfunction

  // Write through the bus and update the model
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
    case (i)
      `BDC_IDX_DEV_CFG2: m_en = d[8];
      `BDC_IDX_BAL_DIAG: {m_alt, m_pol, m_cells} = d[13:0];
      `BDC_IDX_DCHG_CFG: {m_win, m_tmo} = {d[15:13], d[7:0]};
      `BDC_IDX_TOP_CELL: m_top = d[3:0];
      `BDC_IDX_MEAS_EN:  m_cells = d[12:1];
      `BDC_IDX_MUX_POL:  {m_alt, m_pol} = d[1:0];
      `BDC_IDX_INT_MASK: m_mask = d[2:0];
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [7:0] i);
    apb(1'b0, i, 32'h0);
    check(rd, exp_rd(i));
  endtask

  // Watchdog
  initial
  begin
    #(40000 * 5);
    num_errors++;
    final_report();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge i_mclk);
    i_resetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rd_chk(regs[i]);
    apb(1'b1, 8'h50, 32'hFFFFFFFF);
    apb(1'b0, 8'h50, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    $display("Test reset values done");
    for (int k = 0; k < 8; k++)
    begin
      for (int i = 1; i < 7; i++)
      begin
        rnd = lfsr(rnd);
        wr(regs[i], {rnd, lfsr(rnd)});
      end
      if (k == 0)
        wr(`BDC_IDX_TOP_CELL, 32'h0);
      for (int i = 0; i < 7; i++)
        rd_chk(regs[i]);
      check(o_cell_measure_enables, m_cells);
      check({o_alt_mux_select, o_polarity}, {m_alt, m_pol});
      rnd = lfsr(rnd);
      i_balance_switch_alert <= rnd[11:0];
      repeat (3) @(posedge i_mclk);
      eff = (m_top == 4'h0 || m_top > 4'hC) ? 12 : m_top;
      check(o_balance_switch_alert, rnd[11:0] & 12'((1 << eff) - 1));
    end
    i_balance_switch_alert <= '0;
    $display("Test register traffic done");
    for (int w = 0; w < 3; w++)
    begin
      wv = (w == 2) ? 7 : w;
      wr(`BDC_IDX_DEV_CFG2, 32'h0);
      wr(`BDC_IDX_DCHG_CFG, (wv << 13) | 1);
      wr(`BDC_IDX_DEV_CFG2, 32'h100);
      n = 0;
      on = 0;
      off = 0;
      while (o_discharge_switch_on !== 1'b1 && n++ < 100)
        @(posedge i_mclk);
      while (o_discharge_switch_on === 1'b1 && on++ < PER)
        @(posedge i_mclk);
      while (o_discharge_switch_on === 1'b0 && off++ < PER)
        @(posedge i_mclk);
      check(on, (wv == 7 ? 959 : (wv + 1) * 120) * TC);
      check(on + off, PER);
      m_cnt = 4'hE;
      rd_chk(`BDC_IDX_DCHG_CFG);
      if (w == 2)
        wr(`BDC_IDX_DEV_CFG2, 32'h0);
      else
        wr(`BDC_IDX_DCHG_CFG, wv << 13);
      repeat (3) @(posedge i_mclk);
      check(o_discharge_switch_on, 0);
      check(o_emergency_discharge_enable, m_en);
      m_cnt = 4'hF;
      rd_chk(`BDC_IDX_DCHG_CFG);
    end
    $display("Test discharge windows done");
    wr(`BDC_IDX_INT_MASK, 32'h2);
    repeat (2) @(posedge i_mclk);
    check(o_irq, 1);
    apb(1'b0, `BDC_IDX_INT_STATUS, 32'h0);
    check(rd & 32'h3, 32'h2);
    wr(`BDC_IDX_INT_STATUS, 32'h7);
    apb(1'b0, `BDC_IDX_INT_STATUS, 32'h0);
    check(rd, 32'h0);
    check(o_irq, 0);
    i_balance_switch_alert <= 12'h001;
    repeat (3) @(posedge i_mclk);
    i_balance_switch_alert <= '0;
    wr(`BDC_IDX_INT_MASK, 32'h4);
    repeat (2) @(posedge i_mclk);
    check(o_irq, 1);
    wr(`BDC_IDX_INT_MASK, 32'h0);
    repeat (2) @(posedge i_mclk);
    check(o_irq, 0);
    wr(`BDC_IDX_INT_STATUS, 32'h4);
    apb(1'b0, `BDC_IDX_INT_STATUS, 32'h0);
    check(rd, 32'h0);
    $display("Test interrupts done");
    final_report();
  end
endmodule // balance_discharge_config_test
